// >>> common/supply_gpi_defines.vh
// constants for the supply and general purpose line control register bank
// assumes byte-wide registers on an 8-bit register address
`ifndef SUPPLY_GPI_DEFINES_VH
`define SUPPLY_GPI_DEFINES_VH

// register offsets
`define ADDR_LINE3_LINE4_OUT   8'h1f
`define ADDR_FIRST_BUCK_CTRL   8'h21
`define ADDR_THIRD_BUCK_CTRL   8'h22
`define ADDR_SECOND_BUCK_CTRL  8'h24
`define ADDR_FIRST_LINEAR_CTRL 8'h26

// reset values (no documented figure, chosen as all off)
`define RST_LINE3_LINE4_OUT    8'h00
`define RST_SUPPLY_CTRL        8'h00

// writable bit masks, reserved bits are zero
`define MASK_LINE3_LINE4_OUT   8'h1f
`define MASK_BUCK_CTRL         8'h6f
`define MASK_LINEAR_CTRL       8'hef

// field positions
`define LINE4_FUNC_MSB         4
`define LINE4_FUNC_LSB         3
`define LINE3_FUNC_MSB         2
`define LINE3_FUNC_LSB         0
`define VOLT_SEL_MSB           6
`define VOLT_SEL_LSB           5
`define BUCK_CONFIG_BIT        3
`define LINEAR_CONFIG_BIT      7
`define LINEAR_PD_DIS_BIT      3
`define EN_SEL_MSB             2
`define EN_SEL_LSB             1
`define ENABLE_BIT             0

// output function codes
`define FUNC_STATIC            3'h0
`define FUNC_FAULT             3'h1
`define FUNC_SEQ               3'h3
`define FUNC_FWD_IN0           3'h4
`define FUNC_FWD_IN1           3'h5
`define FUNC_FWD_IN2           3'h6

// input select code meaning sequencer control
`define SEL_SEQUENCER          2'h0

`endif

// >>> hdl/supply_gpi_control_regs.v
// control register bank for general purpose lines three/four and for
// three buck converters plus the first linear regulator.
// assumes the two-wire host interface decodes transfers into the byte
// strobes below, and that input lines arrive as clean asserted-high levels.
//
// Contract
// - line four function picks pin driver
// - line three function picks pin driver
// - voltage input edges choose A or B
// - enable input edges switch supply on/off
// - enable bit switches supply via sequencer
// - config bit: default or sequenced-on
// - pull-down disable bit blocks pull-down
// - linear enable bit honours sequencer order
// - polarity bit: static level or active sense
// - software voltage select when not input-driven
`timescale 1ns/1ps
`default_nettype none
`include "supply_gpi_defines.vh"

module supply_gpi_control_regs (
  input  wire       clk,
  input  wire       resetn,
  // register port from the two-wire interface
  input  wire       reg_wr_en,
  input  wire       reg_rd_en,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wr_data,
  output reg  [7:0] reg_rd_data,
  output reg        reg_rd_valid,
  // signals from the rest of the device
  input  wire [3:0] general_purpose_input,
  input  wire       supply_fault_signal,
  input  wire       seq_line_three_drive,
  input  wire       seq_line_four_drive,
  input  wire       line_three_polarity_bit,
  input  wire       line_four_polarity_bit,
  input  wire [3:0] voltage_select_sw,
  // pin drivers
  output reg        line_three_pin_level,
  output reg        line_four_pin_level,
  // supply controls, index 0 first buck, 1 second, 2 third, 3 linear
  output wire [3:0] supply_enable_req,
  output wire [3:0] supply_seq_controlled,
  output reg  [3:0] supply_voltage_b,
  output wire [3:0] supply_config,
  output wire       first_linear_pulldown_on
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // pin level for a given output function; reserved codes hold passive
  function pin_level;
    input [2:0] func;
    input       pol;
    input       fault;
    input       seq;
    input [2:0] fwd;
    reg         act;
    begin
      act = 1'b0;
      case (func)
        `FUNC_FAULT:   act = fault;
        `FUNC_SEQ:     act = seq;
        `FUNC_FWD_IN0: act = fwd[0];
        `FUNC_FWD_IN1: act = fwd[1];
        `FUNC_FWD_IN2: act = fwd[2];
        default:       act = 1'b0;
      endcase
      if (func == `FUNC_STATIC)
        pin_level = pol;
      else
        pin_level = pol ? act : ~act;
    end
  endfunction

  // level of the input chosen by a two-bit select, codes 1..3
  function pick_input;
    input [1:0] sel;
    input [3:0] lvl;
    begin
      case (sel)
        2'h1:    pick_input = lvl[1];
        2'h2:    pick_input = lvl[2];
        2'h3:    pick_input = lvl[3];
        default: pick_input = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0] out_func_reg;
  reg  [7:0] ctrl_reg [0:3];
  reg  [3:0] in_prev_reg;
  reg  [3:0] volt_b_hw_reg;
  reg  [7:0] rd_next;
  reg  [1:0] wr_idx;
  reg        wr_hit;
  reg  [7:0] wr_mask;
  integer    i;
  // separate loop index per process, so no variable has two drivers
  integer    j;

  // write decode; masks keep reserved bits at zero
  always @* begin
    wr_hit  = 1'b1;
    wr_idx  = 2'h0;
    wr_mask = `MASK_BUCK_CTRL;
    case (reg_addr)
      `ADDR_FIRST_BUCK_CTRL:   wr_idx = 2'h0;
      `ADDR_SECOND_BUCK_CTRL:  wr_idx = 2'h1;
      `ADDR_THIRD_BUCK_CTRL:   wr_idx = 2'h2;
      `ADDR_FIRST_LINEAR_CTRL: begin
        wr_idx  = 2'h3;
        wr_mask = `MASK_LINEAR_CTRL;
      end
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_func_reg <= `RST_LINE3_LINE4_OUT;
      in_prev_reg  <= 4'h0;
      volt_b_hw_reg <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        ctrl_reg[i] <= `RST_SUPPLY_CTRL;
    end else begin
      in_prev_reg <= general_purpose_input;
      if (reg_wr_en && reg_addr == `ADDR_LINE3_LINE4_OUT)
        out_func_reg <= reg_wr_data & `MASK_LINE3_LINE4_OUT;
      if (reg_wr_en && wr_hit)
        ctrl_reg[wr_idx] <= reg_wr_data & wr_mask;
      for (i = 0; i < 4; i = i + 1) begin
        // an input edge wins over a software write in the same cycle
        if (ctrl_reg[i][`EN_SEL_MSB:`EN_SEL_LSB] != `SEL_SEQUENCER) begin
          if (pick_input(ctrl_reg[i][`EN_SEL_MSB:`EN_SEL_LSB],
                         general_purpose_input) &&
              !pick_input(ctrl_reg[i][`EN_SEL_MSB:`EN_SEL_LSB], in_prev_reg))
            ctrl_reg[i][`ENABLE_BIT] <= 1'b1;
          else if (!pick_input(ctrl_reg[i][`EN_SEL_MSB:`EN_SEL_LSB],
                               general_purpose_input) &&
                   pick_input(ctrl_reg[i][`EN_SEL_MSB:`EN_SEL_LSB],
                              in_prev_reg))
            ctrl_reg[i][`ENABLE_BIT] <= 1'b0;
        end
        if (pick_input(ctrl_reg[i][`VOLT_SEL_MSB:`VOLT_SEL_LSB],
                       general_purpose_input) &&
            !pick_input(ctrl_reg[i][`VOLT_SEL_MSB:`VOLT_SEL_LSB], in_prev_reg))
          volt_b_hw_reg[i] <= 1'b0;
        else if (!pick_input(ctrl_reg[i][`VOLT_SEL_MSB:`VOLT_SEL_LSB],
                             general_purpose_input) &&
                 pick_input(ctrl_reg[i][`VOLT_SEL_MSB:`VOLT_SEL_LSB],
                            in_prev_reg))
          volt_b_hw_reg[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, one cycle latency, unmapped reads zero

  always @* begin
    case (reg_addr)
      `ADDR_LINE3_LINE4_OUT:   rd_next = out_func_reg;
      `ADDR_FIRST_BUCK_CTRL:   rd_next = ctrl_reg[0];
      `ADDR_SECOND_BUCK_CTRL:  rd_next = ctrl_reg[1];
      `ADDR_THIRD_BUCK_CTRL:   rd_next = ctrl_reg[2];
      `ADDR_FIRST_LINEAR_CTRL: rd_next = ctrl_reg[3];
      default:                 rd_next = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rd_data <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_three_pin_level <= 1'b0;
      line_four_pin_level  <= 1'b0;
      supply_voltage_b     <= 4'h0;
    end else begin
      line_three_pin_level <= pin_level(
        out_func_reg[`LINE3_FUNC_MSB:`LINE3_FUNC_LSB],
        line_three_polarity_bit, supply_fault_signal,
        seq_line_three_drive, general_purpose_input[2:0]);
      // line four has no forwarding codes, its upper code bit is zero
      line_four_pin_level <= pin_level(
        {1'b0, out_func_reg[`LINE4_FUNC_MSB:`LINE4_FUNC_LSB]},
        line_four_polarity_bit, supply_fault_signal,
        seq_line_four_drive, 3'h0);
      for (j = 0; j < 4; j = j + 1)
        supply_voltage_b[j] <=
          (ctrl_reg[j][`VOLT_SEL_MSB:`VOLT_SEL_LSB] == `SEL_SEQUENCER) ?
          voltage_select_sw[j] : volt_b_hw_reg[j];
    end
  end

  // the sequencer applies these requests in its own on/off priority order
  assign supply_enable_req = {ctrl_reg[3][`ENABLE_BIT],
                              ctrl_reg[2][`ENABLE_BIT],
                              ctrl_reg[1][`ENABLE_BIT],
                              ctrl_reg[0][`ENABLE_BIT]};
  assign supply_seq_controlled = {
    ctrl_reg[3][`EN_SEL_MSB:`EN_SEL_LSB] == `SEL_SEQUENCER,
    ctrl_reg[2][`EN_SEL_MSB:`EN_SEL_LSB] == `SEL_SEQUENCER,
    ctrl_reg[1][`EN_SEL_MSB:`EN_SEL_LSB] == `SEL_SEQUENCER,
    ctrl_reg[0][`EN_SEL_MSB:`EN_SEL_LSB] == `SEL_SEQUENCER};
  assign supply_config = {ctrl_reg[3][`LINEAR_CONFIG_BIT],
                          ctrl_reg[2][`BUCK_CONFIG_BIT],
                          ctrl_reg[1][`BUCK_CONFIG_BIT],
                          ctrl_reg[0][`BUCK_CONFIG_BIT]};
  assign first_linear_pulldown_on = ~ctrl_reg[3][`ENABLE_BIT] &
                                    ~ctrl_reg[3][`LINEAR_PD_DIS_BIT];

endmodule
`default_nettype wire

// >>> bench/host_model.sv
// host side of the register port: one byte per transfer
// assumes strobes are sampled on the rising clk and read data lags one edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_en = 1'b0,
  output logic            rd_en = 1'b0,
  output logic [7:0]      addr = 8'h00,
  output logic [7:0]      wdata = 8'h00
);
  ////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    // requests always start on a rising edge, whatever the caller did
    @(posedge clk);
    wr_en <= w;
    rd_en <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // released lines show the inverse so stale values cannot pass
    addr <= ~a;
    wdata <= ~d;
    #1;
    q = rd_data;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/supply_gpi_props.sv
// assertions on the register port and the supply control outputs
// assumes one clock and the asynchronous active-low reset of the bank
`timescale 1ns/1ps
`default_nettype none
module supply_gpi_props (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic       reg_rd_valid,
  input wire logic [3:0] general_purpose_input,
  input wire logic [3:0] supply_enable_req,
  input wire logic [3:0] supply_seq_controlled,
  input wire logic [3:0] supply_config,
  input wire logic       first_linear_pulldown_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic w21 = reg_wr_en && reg_addr == 8'h21;
  wire logic w24 = reg_wr_en && reg_addr == 8'h24;
  wire logic w26 = reg_wr_en && reg_addr == 8'h26;
  ////////////////////////////////////////////////////////////
  property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid late");
  property p_rd_hold; !reg_rd_en |=> $stable(reg_rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; reg_rd_en && !(reg_addr inside {8'h1f, 8'h21,
    8'h22, 8'h24, 8'h26}) |=> reg_rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read");
  property p_reserved; reg_rd_en && reg_addr[7:4] == 4'h2 && reg_addr !=
    8'h26 |=> !reg_rd_data[7] && !reg_rd_data[4]; endproperty
  a_reserved: assert property (p_reserved) else $error("spare bit");
  property p_buck_en; w21 && $stable(general_purpose_input) |=>
    supply_enable_req[0] == $past(reg_wr_data[0]); endproperty
  a_buck_en: assert property (p_buck_en) else $error("buck enable");
  property p_conf; w21 ##1 1'b1 |-> supply_config[0] ==
    $past(reg_wr_data[3]); endproperty
  a_conf: assert property (p_conf) else $error("buck config");
  property p_seq; w24 |=> supply_seq_controlled[1] ==
    ($past(reg_wr_data[2:1]) == 2'h0); endproperty
  a_seq: assert property (p_seq) else $error("enable select");
  property p_pulldown; w26 && !reg_wr_data[0] && $stable(
    general_purpose_input) |=> first_linear_pulldown_on ==
    !$past(reg_wr_data[3]); endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down");
  property p_ldo; w26 && $stable(general_purpose_input) |=> supply_config[3]
    == $past(reg_wr_data[7]) && supply_enable_req[3] ==
    $past(reg_wr_data[0]); endproperty
  a_ldo: assert property (p_ldo) else $error("linear control");
endmodule
bind supply_gpi_control_regs supply_gpi_props props (.clk(clk),
  .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
  .reg_rd_valid(reg_rd_valid), .general_purpose_input(general_purpose_input),
  .supply_enable_req(supply_enable_req), .supply_config(supply_config),
  .supply_seq_controlled(supply_seq_controlled),
  .first_linear_pulldown_on(first_linear_pulldown_on));
`default_nettype wire

// >>> bench/tb_supply_gpi_control_regs.sv
// self-checking bench for the supply and line control register bank
// assumes host_model drives the register port, clock 50 MHz
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_supply_gpi_control_regs;
  logic       clk = 1'b0, resetn = 1'b0, fault = 1'b0, seq3 = 1'b0;
  logic       seq4 = 1'b0, pol3 = 1'b0, pol4 = 1'b0, we, re, rv, p3, p4, pd;
  logic [3:0] gpi = 4'h0, vsw = 4'h0, en, sq, vb, cf;
  logic [7:0] a, d, rd, q, x3;
  int         err_count = 0, checks = 0, cyc = 0, i, k, l;
  int unsigned s = 70;
  logic [7:0] ad[5] = '{8'h1f, 8'h21, 8'h24, 8'h22, 8'h26};
  logic [7:0] mk[5] = '{8'h1f, 8'h6f, 8'h6f, 8'h6f, 8'hef};
  logic [7:0] mr[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end
  host_model hm (.clk(clk), .rd_data(rd), .wr_en(we), .rd_en(re), .addr(a),
    .wdata(d));
  supply_gpi_control_regs DUT (.clk(clk), .resetn(resetn), .reg_wr_en(we),
    .reg_rd_en(re), .reg_addr(a), .reg_wr_data(d), .reg_rd_data(rd),
    .reg_rd_valid(rv), .general_purpose_input(gpi),
    .supply_fault_signal(fault), .seq_line_three_drive(seq3),
    .seq_line_four_drive(seq4), .line_three_polarity_bit(pol3),
    .line_four_polarity_bit(pol4), .voltage_select_sw(vsw),
    .line_three_pin_level(p3), .line_four_pin_level(p4),
    .supply_enable_req(en), .supply_seq_controlled(sq),
    .supply_voltage_b(vb), .supply_config(cf), .first_linear_pulldown_on(pd));
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  // reserved codes are taken as the passive level
  function automatic logic drv(logic [2:0] c, logic p, logic x);
    if (c == 3'h0) return p;
    if (c == 3'h2 || c == 3'h7) return ~p;
    return p ? x : ~x;
  endfunction
  task automatic wr(int j, logic [7:0] v);
    hm.xfer(1'b1, ad[j], v, q);
    mr[j] = v & mk[j];
  endtask
  task automatic rdchk(int j);
    hm.xfer(1'b0, ad[j], 8'h00, q);
    `CHK("readback", mr[j], q)
  endtask
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    `CHK("pulldown", 1'b1, pd)
    for (i = 0; i < 5; i++) rdchk(i);
    for (k = 0; k < 8; k++) begin
      q = rnd();
      wr(0, {q[7:5], k[1:0], k[2:0]});
      {pol3, pol4, fault, seq3, seq4, gpi[2:0]} <= rnd();
      repeat (3) @(posedge clk);
      #1;
      x3 = {1'b0, gpi[2:0], seq3, 1'b0, fault, 1'b0};
      `CHK("line3", drv(k[2:0], pol3, x3[k[2:0]]), p3)
      x3 = {4'h0, seq4, 1'b0, fault, 1'b0};
      `CHK("line4", drv({1'b0, k[1:0]}, pol4, x3[k[1:0]]), p4)
      `CHK("ignored", 4'h0, en)
    end
    @(posedge clk);
    gpi <= 4'h0;
    vsw <= 4'hf;
    repeat (3) @(posedge clk);
    #1;
    `CHK("sw volt", 4'hf, vb)
    for (i = 0; i < 4; i++) begin
      k = 1 + i % 3;
      l = 1 + (i + 1) % 3;
      wr(i + 1, {1'b0, l[1:0], 2'b00, k[1:0], 1'b0});
      gpi[k] <= 1'b1;
      gpi[l] <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("en up", 1'b1, en[i])
      `CHK("volt a", 1'b0, vb[i])
      mr[i + 1][0] = 1'b1;
      rdchk(i + 1);
      gpi[k] <= 1'b0;
      gpi[l] <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("en down", 1'b0, en[i])
      `CHK("volt b", 1'b1, vb[i])
      // a second rise must pull the supply back from B to A
      @(posedge clk);
      gpi[l] <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("volt a again", 1'b0, vb[i])
      @(posedge clk);
      gpi[l] <= 1'b0;
      wr(i + 1, 8'h00);
    end
    for (i = 0; i < 24; i++) begin
      k = rnd() % 5;
      wr(k, rnd());
      rdchk(k);
      if (k > 0) begin
        `CHK("enable", mr[k][0], en[k - 1])
        `CHK("config", mr[k][k == 4 ? 7 : 3], cf[k - 1])
        `CHK("seq", mr[k][2:1] == 2'h0, sq[k - 1])
        `CHK("pd", !(mr[4][0] | mr[4][3]), pd)
      end
    end
    hm.xfer(1'b1, 8'h23, rnd(), q);
    hm.xfer(1'b0, 8'h23, 8'h00, q);
    `CHK("hole", 8'h00, q)
    for (i = 1; i < 5; i++) wr(i, 8'h00);
    vsw <= 4'(rnd());
    repeat (3) @(posedge clk);
    #1;
    `CHK("sw volt", vsw, vb)
    test_done();
  end
endmodule
`default_nettype wire
